//--- verification/ofnrd_pixel_model.sv
// Pixel array stand-in that feeds the dump path of the readout
`timescale 1ns/1ns
module ofnrd_pixel_model
  import ofnrd_pkg::*;
(
  // Dump pointer
  input wire logic [PTR_W-1:0] dump_addr,
  // Pixel value
  output logic [7:0] dump_pixel
);
  // Value follows the address so each byte is traceable
  assign dump_pixel = dump_addr[7:0] + 8'h11;
endmodule

//--- verification/tb.sv
// Self-checking bench for the readout block
`timescale 1ns/1ns
module tb;
  import ofnrd_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, move_valid, frame_done, gpio_pin, mount_direction_pin;
  logic [PADDR_W-1:0] paddr;
  logic [PDATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, irq, err;
  logic signed [7:0] move_dx, move_dy;
  ofnrd_frame_s frame_stats;
  logic [7:0] dump_pixel, hi;
  logic [PTR_W-1:0] dump_addr;
  logic [15:0] exposure_time, e0;
  int bad_count, cmp_count;
  ofnrd_readout ofnrd_readout_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .move_valid(move_valid), .move_dx(move_dx), .move_dy(move_dy), .frame_done(frame_done),
    .frame_stats(frame_stats), .dump_pixel(dump_pixel), .dump_addr(dump_addr),
    .exposure_time(exposure_time), .gpio_pin(gpio_pin), .mount_direction_pin(mount_direction_pin));
  ofnrd_pixel_model ofnrd_pixel_model_inst (.dump_addr(dump_addr), .dump_pixel(dump_pixel));
  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("wait states", n, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask
  task automatic mv(input int n, input logic signed [7:0] dx, input logic signed [7:0] dy);
    @(posedge pclk);
    move_valid <= 1'b1;
    move_dx <= dx;
    move_dy <= dy;
    repeat (n) @(posedge pclk);
    move_valid <= 1'b0;
  endtask
  task automatic frame(input logic [8:0] fc, input logic [7:0] mp, input logic [16:0] ps);
    @(posedge pclk);
    frame_done <= 1'b1;
    frame_stats <= {fc, mp, ps};
    @(posedge pclk);
    frame_done <= 1'b0;
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial
  begin
    #2000000;
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    move_valid = 1'b0;
    move_dx = 8'sh00;
    move_dy = 8'sh00;
    frame_done = 1'b0;
    frame_stats = '0;
    gpio_pin = 1'b0;
    mount_direction_pin = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(IDX_STATUS, 32'h0, "status reset");
    chk("status err", err, 1'b0);
    chk("exposure reset", exposure_time, EXP_RESET);
    $display("test reset done");
    mv(1, 8'sh05, 8'shfd);
    rdc(IDX_STATUS, 32'h80, "status moved");
    rdc(IDX_DX, 32'h05, "dx");
    rdc(IDX_DY, 32'hfd, "dy");
    rdc(IDX_DX, 32'h00, "dx cleared");
    rdc(IDX_STATUS, 32'h00, "status idle");
    $display("test motion done");
    mv(2, 8'sh64, 8'sh9c);
    rdc(IDX_DX, 32'h7f, "dx max");
    rdc(IDX_DY, 32'h80, "dy min pin low");
    wr(IDX_STATUS, 32'hff);
    mount_direction_pin <= 1'b1;
    mv(2, 8'sh9c, 8'sh9c);
    rdc(IDX_DX, 32'h81, "dx min");
    rdc(IDX_DY, 32'h81, "dy min pin high");
    wr(IDX_STATUS, 32'h0);
    $display("test clamp done");
    mv(6, 8'sh64, 8'sh00);
    rdc(IDX_STATUS, 32'h90, "status overflow");
    wr(IDX_STATUS, 32'h0);
    rdc(IDX_STATUS, 32'h00, "status write clears");
    rdc(IDX_DX, 32'h00, "dx after clear");
    gpio_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    rdc(IDX_STATUS, 32'h01, "gpio high");
    gpio_pin <= 1'b0;
    $display("test overflow done");
    frame(9'h1ff, 8'hff, 17'h12345);
    rdc(IDX_SURFACE_QUALITY, 32'ha7, "quality clamp");
    rdc(IDX_MAXPIX, 32'hfe, "brightest clamp");
    rdc(IDX_PSUM, 32'h91, "total");
    wr(IDX_SURFACE_QUALITY, 32'h0);
    rdc(IDX_SURFACE_QUALITY, 32'ha7, "quality read only");
    frame(9'h08e, 8'h40, 17'h00400);
    rdc(IDX_SURFACE_QUALITY, 32'h47, "quality");
    rdc(IDX_MAXPIX, 32'h40, "brightest");
    rdc(IDX_PSUM, 32'h02, "total small");
    e0 = exposure_time;
    repeat (3) frame(9'h0, 8'hf8, 17'h0);
    // Let the last frame's exposure step settle
    @(posedge pclk);
    chk("exposure falls", exposure_time < e0, 1'b1);
    rdc(IDX_EXP_HI, {24'h0, exposure_time[15:8]}, "exposure high");
    hi = rd[7:0];
    e0 = exposure_time;
    repeat (2) frame(9'h0, 8'hf8, 17'h0);
    rdc(IDX_EXP_LO, {24'h0, e0[7:0]}, "exposure low latched");
    chk("exposure pair", {hi, rd[7:0]}, e0);
    $display("test frame done");
    wr(IDX_DUMP, 32'h0);
    rdc(IDX_STATUS, 32'h20, "origin after restart");
    for (int i = 0; i <= 360; i++)
    begin
      frame(9'h0, 8'h00, 17'h0);
      rdc(IDX_STATUS, (i == 0) ? 32'h60 : 32'h40, "dump valid");
      rdc(IDX_DUMP, {24'h0, 8'(i) + 8'h11}, "dump byte");
    end
    rdc(IDX_STATUS, 32'h20, "origin after wrap");
    $display("test dump done");
    wr(IDX_IRQ_STAT, 32'h7);
    wr(IDX_IRQ_MASK, 32'h1);
    rdc(IDX_IRQ_MASK, 32'h1, "mask");
    chk("irq idle", irq, 1'b0);
    mv(1, 8'sh01, 8'sh00);
    repeat (3) @(posedge pclk);
    chk("irq raised", irq, 1'b1);
    rdc(IDX_IRQ_STAT, 32'h1, "irq status");
    wr(IDX_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    wr(IDX_STATUS, 32'h0);
    wr(IDX_IRQ_MASK, 32'h0);
    mv(1, 8'sh01, 8'sh00);
    repeat (3) @(posedge pclk);
    chk("irq masked", irq, 1'b0);
    rdc(IDX_IRQ_STAT, 32'h1, "irq status masked");
    $display("test irq done");
    apb(1'b0, 10'h0c0, 32'h0);
    chk("unmapped err", err, 1'b1);
    apb(1'b0, 10'h00d, 32'h0);
    chk("misaligned err", err, 1'b1);
    rdc(IDX_DX, 32'h01, "dx kept after refused read");
    $display("test errors done");
    conclude();
  end
endmodule

//--- verilog/ofnrd_axis_accum.sv
// Saturating displacement accumulator for one axis
`timescale 1ns/1ns
module ofnrd_axis_accum
  import ofnrd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Movement and host actions
  input wire logic move_valid,
  input wire logic signed [7:0] move_delta,
  input wire logic read_take,
  input wire logic signed [7:0] taken,
  input wire logic clear,
  input wire logic signed [7:0] min_lim,
  // Report
  output ofnrd_axis_s axis
);
  typedef struct packed {
    logic signed [ACC_W-1:0] acc;
    logic ovf;
  } ofnrd_acc_s;
  ofnrd_acc_s s_q;
  ofnrd_acc_s s_d;
  logic signed [ACC_W+1:0] sum;
  logic fits;

  always_comb
  begin
    s_d = s_q;
    sum = {{2{s_q.acc[ACC_W-1]}}, s_q.acc};
    if (clear)
      sum = '0;
    else if (read_take)
      sum = sum - {{4{taken[7]}}, taken};
    if (move_valid)
      sum = sum + {{4{move_delta[7]}}, move_delta};
    fits = (sum[ACC_W+1:ACC_W-1] == 3'h0) || (sum[ACC_W+1:ACC_W-1] == 3'h7);
    if (!fits)
    begin
      s_d.acc = sum[ACC_W+1] ? ACC_MIN : ACC_MAX; // see [RULE6]
      s_d.ovf = 1'b1;
    end
    else
    begin
      s_d.acc = sum[ACC_W-1:0];
      if (clear || (read_take && s_d.acc != ACC_MAX && s_d.acc != ACC_MIN))
        s_d.ovf = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Clamp the reported byte
  assign axis.report = (s_q.acc > DISP_MAX) ? DISP_MAX : (s_q.acc < min_lim) ? min_lim : s_q.acc[7:0]; // see [RULE8]
  assign axis.pending = (s_q.acc != '0);
  assign axis.ovf = s_q.ovf;
endmodule

//--- verilog/ofnrd_exposure.sv
// Automatic exposure time control
`timescale 1ns/1ns
module ofnrd_exposure
  import ofnrd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame results
  input wire logic frame_done,
  input wire logic [7:0] max_pixel,
  input wire logic [7:0] psum_byte,
  // Exposure in clock cycles
  output logic [15:0] exposure
);
  typedef struct packed {
    logic [15:0] exp;
  } ofnrd_exp_s;
  ofnrd_exp_s s_q;
  ofnrd_exp_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (frame_done)
    begin
      if ((max_pixel >= MAXPIX_HIGH) || (psum_byte > PSUM_HIGH))
        s_d.exp = (s_q.exp > EXP_MIN) ? s_q.exp - EXP_STEP : EXP_MIN; // see [RULE14]
      else if ((max_pixel < MAXPIX_LOW) && (psum_byte < PSUM_LOW))
        s_d.exp = (s_q.exp < EXP_MAX) ? s_q.exp + EXP_STEP : EXP_MAX; // see [RULE14]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q.exp <= EXP_RESET;
    else
      s_q <= s_d;
  end

  assign exposure = s_q.exp;

  property p_exp_darken;
    @(posedge pclk) disable iff (!presetn)
    frame_done && (max_pixel >= MAXPIX_HIGH) && (s_q.exp > EXP_MIN) |=> exposure == $past(exposure) - EXP_STEP;
  endproperty
  a_exp_darken: assert property (p_exp_darken) // see [RULE14]
    else $error("Exposure not reduced on bright frame");
endmodule

//--- verilog/ofnrd_pkg.sv
// Constants and carrier types for the motion and frame statistics readout
package ofnrd_pkg;
  // APB geometry
  localparam int PADDR_W = 10;
  localparam int PDATA_W = 32;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h02;
  localparam logic [7:0] IDX_DX = 8'h03;
  localparam logic [7:0] IDX_DY = 8'h04;
  localparam logic [7:0] IDX_SURFACE_QUALITY = 8'h05;
  localparam logic [7:0] IDX_EXP_HI = 8'h06;
  localparam logic [7:0] IDX_EXP_LO = 8'h07;
  localparam logic [7:0] IDX_MAXPIX = 8'h08;
  localparam logic [7:0] IDX_PSUM = 8'h09;
  localparam logic [7:0] IDX_DUMP = 8'h0b;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  // Movement status fields
  localparam int STAT_MOT_BIT = 7;
  localparam int STAT_DUMP_BIT = 6;
  localparam int STAT_ORIGIN_BIT = 5;
  localparam int STAT_OVF_BIT = 4;
  localparam int STAT_PIN_BIT = 0;
  // Interrupt status and mask fields
  localparam int IRQ_MOT_BIT = 0;
  localparam int IRQ_DUMP_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  // Displacement limits
  localparam int ACC_W = 10;
  localparam logic signed [7:0] DISP_MAX = 8'sh7f;
  localparam logic signed [7:0] DISP_MIN_PIN_HIGH = 8'sh81;
  localparam logic signed [7:0] DISP_MIN_PIN_LOW = 8'sh80;
  localparam logic signed [ACC_W-1:0] ACC_MAX = 10'sh1ff;
  localparam logic signed [ACC_W-1:0] ACC_MIN = 10'sh200;
  // Frame statistics
  localparam logic [7:0] SURFACE_QUALITY_MAX = 8'ha7;
  localparam logic [7:0] MAXPIX_MAX = 8'hfe;
  localparam int PSUM_LSB = 9;
  // Pixel dump pointer
  localparam int PTR_W = 9;
  localparam logic [PTR_W-1:0] DUMP_LAST = 9'h168;
  // Exposure control
  localparam logic [15:0] EXP_RESET = 16'h0100;
  localparam logic [15:0] EXP_STEP = 16'h0010;
  localparam logic [15:0] EXP_MIN = 16'h0010;
  localparam logic [15:0] EXP_MAX = 16'hffe0;
  localparam logic [7:0] MAXPIX_HIGH = 8'hf0;
  localparam logic [7:0] MAXPIX_LOW = 8'h80;
  localparam logic [7:0] PSUM_HIGH = 8'hb4;
  localparam logic [7:0] PSUM_LOW = 8'h3c;
  typedef struct packed {
    logic [8:0] feature_count;
    logic [7:0] max_pixel;
    logic [16:0] pixel_sum;
  } ofnrd_frame_s;
  typedef struct packed {
    logic signed [7:0] report;
    logic pending;
    logic ovf;
  } ofnrd_axis_s;
endpackage

//--- verilog/ofnrd_readout.sv
// Motion and frame statistics readout with APB register access
//
// What this block and the host do
// [RULE1] Flag dump byte valid while byte waits
// [RULE2] Host checks dump flag before reading byte
// [RULE3] Host checks origin flag after dump restart
// [RULE4] Pending bit shows unreported motion
// [RULE5] Origin flag on restart or pointer wrap
// [RULE6] Overflow bit on accumulator overflow
// [RULE7] Status bit zero mirrors general pin
// [RULE8] X byte clamped to plus/minus 127, clear-on-read; a read subtracts the clamped byte, keeping any excess
// [RULE9] Y byte clamped, -128 floor when pin low
// [RULE10] Host reads X then Y back to back
// [RULE11] Surface quality upper feature bits, max 167
// [RULE12] Exposure high and low byte split
// [RULE13] Host reads exposure high then low
// [RULE14] Exposure tracks pixel brightness automatically
// [RULE15] Brightest pixel per frame, max 254
// [RULE16] Status write clears motion and overflow
// [RULE17] Brightness total is pixel sum over 512
// [RULE18] High byte read latches low byte
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
module ofnrd_readout
  import ofnrd_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [PDATA_W-1:0] pwdata,
  output logic [PDATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Motion engine
  input wire logic move_valid,
  input wire logic signed [7:0] move_dx,
  input wire logic signed [7:0] move_dy,
  // Frame engine
  input wire logic frame_done,
  input wire ofnrd_frame_s frame_stats,
  input wire logic [7:0] dump_pixel,
  output logic [PTR_W-1:0] dump_addr,
  output logic [15:0] exposure_time,
  // Pins
  input wire logic gpio_pin,
  input wire logic mount_direction_pin
);

////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [PDATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] surface_quality;
    logic [7:0] maxpix;
    logic [7:0] psum;
    logic [7:0] exp_lo;
    logic [7:0] dump_data;
    logic dump_valid;
    logic dump_origin;
    logic [PTR_W-1:0] dump_ptr;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic mot_prev;
    logic ovf_prev;
    logic dump_prev;
  } ofnrd_top_s;

  ofnrd_top_s s_q;
  ofnrd_top_s s_d;
  ofnrd_axis_s axis [2];
  logic signed [7:0] axis_delta [2];
  logic signed [7:0] axis_min [2];
  logic axis_take [2];
  logic [15:0] exposure;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic movement_pending;
  logic ovf;
  logic status_clr;
  logic [IRQ_W-1:0] events;

////////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic at_idx(input logic [PADDR_W-1:0] a, input logic [7:0] idx);
    return a[PADDR_W-1:2] == idx;
  endfunction

  function automatic logic mapped(input logic [PADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (at_idx(a, IDX_STATUS) || at_idx(a, IDX_DUMP) || at_idx(a, IDX_IRQ_STAT) ||
      at_idx(a, IDX_IRQ_MASK) || (a[PADDR_W-1:2] >= IDX_DX && a[PADDR_W-1:2] <= IDX_PSUM));
  endfunction

  assign setup = psel & ~penable;
  assign done = psel & penable & s_q.pready;
  // Refused transfers have no side effect other than a refused high exposure byte read latching the low byte
  assign wr = done & pwrite & ~s_q.pslverr;
  assign rd = done & ~pwrite & ~s_q.pslverr;
  assign status_clr = wr & at_idx(paddr, IDX_STATUS); // see [RULE16]

////////////////////////////////////////////////////////////////////////////////
  // Displacement accumulators
  assign movement_pending = axis[0].pending | axis[1].pending; // see [RULE4]
  assign ovf = axis[0].ovf | axis[1].ovf; // see [RULE6]
  assign axis_delta[0] = move_dx;
  assign axis_delta[1] = move_dy;
  assign axis_min[0] = DISP_MIN_PIN_HIGH; // see [RULE8]
  assign axis_min[1] = mount_direction_pin ? DISP_MIN_PIN_HIGH : DISP_MIN_PIN_LOW; // see [RULE9]
  assign axis_take[0] = rd & at_idx(paddr, IDX_DX); // see [RULE8]
  assign axis_take[1] = rd & at_idx(paddr, IDX_DY); // see [RULE9]

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_axis
      ofnrd_axis_accum u_accum (
        .pclk(pclk),
        .presetn(presetn),
        .move_valid(move_valid),
        .move_delta(axis_delta[g]),
        .read_take(axis_take[g]),
        .taken(s_q.prdata[7:0]),
        .clear(status_clr),
        .min_lim(axis_min[g]),
        .axis(axis[g])
      );
    end
  endgenerate

  // Exposure control
  ofnrd_exposure u_exposure (
    .pclk(pclk),
    .presetn(presetn),
    .frame_done(frame_done),
    .max_pixel(s_q.maxpix),
    .psum_byte(s_q.psum),
    .exposure(exposure)
  );

////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    events = '0;
    s_d.pready = setup;
    s_d.pslverr = setup & ~mapped(paddr);
    if (setup & ~pwrite)
    begin
      s_d.prdata = '0;
      case (paddr[PADDR_W-1:2])
        IDX_STATUS:
        begin
          s_d.prdata[STAT_MOT_BIT] = movement_pending; // see [RULE4]
          s_d.prdata[STAT_DUMP_BIT] = s_q.dump_valid; // see [RULE1]
          s_d.prdata[STAT_ORIGIN_BIT] = s_q.dump_origin; // see [RULE5]
          s_d.prdata[STAT_OVF_BIT] = ovf; // see [RULE6]
          s_d.prdata[STAT_PIN_BIT] = gpio_pin; // see [RULE7]
        end
        IDX_DX: s_d.prdata[7:0] = axis[0].report;
        IDX_DY: s_d.prdata[7:0] = axis[1].report;
        IDX_SURFACE_QUALITY: s_d.prdata[7:0] = s_q.surface_quality;
        IDX_EXP_HI:
        begin
          s_d.prdata[7:0] = exposure[15:8]; // see [RULE12]
          s_d.exp_lo = exposure[7:0]; // see [RULE18]
        end
        IDX_EXP_LO: s_d.prdata[7:0] = s_q.exp_lo; // see [RULE12]
        IDX_MAXPIX: s_d.prdata[7:0] = s_q.maxpix;
        IDX_PSUM: s_d.prdata[7:0] = s_q.psum;
        IDX_DUMP: s_d.prdata[7:0] = s_q.dump_data;
        IDX_IRQ_STAT: s_d.prdata[IRQ_W-1:0] = s_q.irq_stat;
        IDX_IRQ_MASK: s_d.prdata[IRQ_W-1:0] = s_q.irq_mask;
        default: s_d.prdata = '0;
      endcase
    end
    // Frame statistics
    if (frame_done)
    begin
      s_d.surface_quality = (frame_stats.feature_count[8:1] > SURFACE_QUALITY_MAX) ? SURFACE_QUALITY_MAX : frame_stats.feature_count[8:1]; // see [RULE11]
      s_d.maxpix = (frame_stats.max_pixel > MAXPIX_MAX) ? MAXPIX_MAX : frame_stats.max_pixel; // see [RULE15]
      s_d.psum = frame_stats.pixel_sum[16:PSUM_LSB]; // see [RULE17]
    end
    // Pixel dump
    if (wr & at_idx(paddr, IDX_DUMP))
    begin
      s_d.dump_ptr = '0; // see [RULE5]
      s_d.dump_valid = 1'b0;
      s_d.dump_origin = 1'b1; // see [RULE5]
    end
    else
    begin
      if (rd & at_idx(paddr, IDX_DUMP) & s_q.dump_valid)
      begin
        s_d.dump_valid = 1'b0;
        s_d.dump_ptr = (s_q.dump_ptr == DUMP_LAST) ? '0 : s_q.dump_ptr + 9'h001;
        s_d.dump_origin = (s_q.dump_ptr == DUMP_LAST); // see [RULE5]
      end
      if (frame_done & ~s_q.dump_valid)
      begin
        s_d.dump_data = dump_pixel;
        s_d.dump_valid = 1'b1; // see [RULE1]
      end
    end
    // Interrupts
    events[IRQ_MOT_BIT] = movement_pending & ~s_q.mot_prev;
    events[IRQ_DUMP_BIT] = s_q.dump_valid & ~s_q.dump_prev;
    events[IRQ_OVF_BIT] = ovf & ~s_q.ovf_prev;
    s_d.mot_prev = movement_pending;
    s_d.ovf_prev = ovf;
    s_d.dump_prev = s_q.dump_valid;
    if (wr & at_idx(paddr, IDX_IRQ_STAT))
      s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
    if (wr & at_idx(paddr, IDX_IRQ_MASK))
      s_d.irq_mask = pwdata[IRQ_W-1:0];
    s_d.irq_stat = s_d.irq_stat | events;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.irq_mask <= IRQ_MASK_RESET;
    end
    else
      s_q <= s_d;
  end

  // Outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign dump_addr = s_q.dump_ptr;
  assign exposure_time = exposure;

////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_dump_fill;
    frame_done && !s_q.dump_valid && !(wr && at_idx(paddr, IDX_DUMP)) |=> s_q.dump_valid;
  endproperty
  a_dump_fill: assert property (p_dump_fill) // see [RULE1]
    else $error("Dump byte not flagged after frame");

  property p_mot_bit;
    setup && !pwrite && at_idx(paddr, IDX_STATUS) |=> s_q.prdata[STAT_MOT_BIT] == $past(movement_pending) && pready;
  endproperty
  a_mot_bit: assert property (p_mot_bit) // see [RULE4]
    else $error("Pending bit does not match motion");

  property p_origin;
    wr && at_idx(paddr, IDX_DUMP) |=> s_q.dump_origin && (s_q.dump_ptr == '0) && !s_q.dump_valid;
  endproperty
  a_origin: assert property (p_origin) // see [RULE5]
    else $error("Dump restart did not reach origin");

  property p_ovf_bit;
    setup && !pwrite && at_idx(paddr, IDX_STATUS) |=> s_q.prdata[STAT_OVF_BIT] == $past(ovf);
  endproperty
  a_ovf_bit: assert property (p_ovf_bit) // see [RULE6]
    else $error("Overflow bit does not match accumulators");

  property p_pin_bit;
    setup && !pwrite && at_idx(paddr, IDX_STATUS) |=> s_q.prdata[STAT_PIN_BIT] == $past(gpio_pin);
  endproperty
  a_pin_bit: assert property (p_pin_bit) // see [RULE7]
    else $error("Pin bit does not mirror pin");

  property p_dx_range;
    setup && !pwrite && at_idx(paddr, IDX_DX) |=> ($signed(s_q.prdata[7:0]) >= DISP_MIN_PIN_HIGH) && (s_q.prdata[31:8] == '0);
  endproperty
  a_dx_range: assert property (p_dx_range) // see [RULE8]
    else $error("X byte outside limits");

  property p_dy_range;
    setup && !pwrite && at_idx(paddr, IDX_DY) && mount_direction_pin |=> s_q.prdata[7:0] != DISP_MIN_PIN_LOW;
  endproperty
  a_dy_range: assert property (p_dy_range) // see [RULE9]
    else $error("Y byte below floor with pin high");

  property p_surface_quality;
    frame_done |=> s_q.surface_quality <= SURFACE_QUALITY_MAX;
  endproperty
  a_surface_quality: assert property (p_surface_quality) // see [RULE11]
    else $error("Surface quality above limit");

  property p_exp_hi;
    setup && !pwrite && at_idx(paddr, IDX_EXP_HI) |=> s_q.prdata[7:0] == $past(exposure[15:8]);
  endproperty
  a_exp_hi: assert property (p_exp_hi) // see [RULE12]
    else $error("Exposure high byte wrong");

  property p_maxpix;
    frame_done |=> s_q.maxpix <= MAXPIX_MAX;
  endproperty
  a_maxpix: assert property (p_maxpix) // see [RULE15]
    else $error("Brightest value above limit");

  property p_status_clr;
    status_clr && !move_valid |=> !movement_pending && !ovf;
  endproperty
  a_status_clr: assert property (p_status_clr) // see [RULE16]
    else $error("Status write did not clear motion");

  property p_psum;
    frame_done |=> s_q.psum == $past(frame_stats.pixel_sum[16:PSUM_LSB]);
  endproperty
  a_psum: assert property (p_psum) // see [RULE17]
    else $error("Brightness total not sum over 512");

  property p_exp_latch;
    setup && !pwrite && at_idx(paddr, IDX_EXP_HI) ##1 !(setup && !pwrite && at_idx(paddr, IDX_EXP_HI)) |=>
      s_q.exp_lo == $past(exposure[7:0], 2);
  endproperty
  a_exp_latch: assert property (p_exp_latch) // see [RULE18]
    else $error("Low exposure byte not latched");
endmodule
